/* File: design/rtcpig_pkg.sv */
/*
 * rtcpig_pkg: constants shared by the periodic interrupt generator.
 * Assumes a 50 MHz system clock and a 32768 Hz timebase made from it.
 */
package rtcpig_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int TICK_HZ = 32768;
  localparam int SUB_W = 15;
  localparam logic [14:0] SUB_HALF_LAST = 15'h3fff;
  localparam logic [14:0] SUB_HALF = 15'h4000;
  // seconds increment lags the pulse-mode falling edge (least time, round up)
  localparam int INC_DELAY_US = 92;
  localparam int INC_DELAY_TICKS = (INC_DELAY_US * TICK_HZ + 999999) / 1000000;
  // largest trim of one second (longest time, round down)
  localparam int ADJ_MAX_US = 3784;
  localparam int ADJ_MAX_TICKS = (ADJ_MAX_US * TICK_HZ) / 1000000;
  localparam int ADJ_PERIOD_S = 20;

  localparam logic [3:0] SEL_P2HZ = 4'h2;
  localparam logic [3:0] SEL_P1HZ = 4'h3;
  localparam logic [3:0] SEL_LSEC = 4'h4;
  localparam logic [3:0] SEL_LMIN = 4'h5;
  localparam logic [3:0] SEL_LHOUR = 4'h6;
  localparam logic [3:0] SEL_LMONTH = 4'h7;

  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_FLAG = 5'h04;
  localparam logic [4:0] OFF_TIME = 5'h08;
  localparam logic [4:0] OFF_MLEN = 5'h0c;
  localparam logic [4:0] OFF_ISTAT = 5'h10;
  localparam logic [4:0] OFF_IMASK = 5'h14;

  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_ADJEN_BIT = 3;
  localparam int CTRL_ADJ_LSB = 8;
  localparam int TIME_SEC_LSB = 0;
  localparam int TIME_MIN_LSB = 8;
  localparam int TIME_HOUR_LSB = 16;
  localparam int TIME_DAY_LSB = 24;
  localparam int ISTAT_PERIODIC_BIT = 0;
  localparam int ISTAT_SECOND_BIT = 1;

  localparam logic [2:0] CTRL_SEL_RST = 3'h0;
  localparam logic [4:0] MLEN_RST = 5'h1f;
  localparam logic [4:0] DAY_RST = 5'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RTCPIG_OFF, RTCPIG_PULSE2, RTCPIG_PULSE1,
    RTCPIG_LSEC, RTCPIG_LMIN, RTCPIG_LHOUR, RTCPIG_LMONTH
  } rtcpig_mode_e;
endpackage

/* File: design/rtcpig_tick_gen.sv */
/*
 * rtcpig_tick_gen: fractional divider giving a one-cycle enable at the
 * timebase rate. Assumes a free-running clock and synchronous reset.
 */
`timescale 1ns/1ps
module rtcpig_tick_gen #(
  parameter int CLK_HZ = rtcpig_pkg::CLK_HZ,
  parameter int TICK_HZ = rtcpig_pkg::TICK_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  import rtcpig_pkg::*;

  initial begin
    // one tick per clock is the fastest the accumulator can serve
    if (TICK_HZ <= 0 || TICK_HZ > CLK_HZ) begin
      $error("tick rate must not exceed the clock rate");
    end
  end

  logic [31:0] acc;
  logic [31:0] next_acc;
  logic next_tick;

  // average rate exact; single ticks jitter by one clock
  always_comb begin
    next_acc = acc + 32'(TICK_HZ);
    next_tick = 1'b0;
    if (next_acc >= 32'(CLK_HZ)) begin
      next_acc = next_acc - 32'(CLK_HZ);
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 32'h0;
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tick <= next_tick;
    end
  end
endmodule // rtcpig_tick_gen

/* File: design/rtcpig_periodic_irq.sv */
/*
 * rtcpig_periodic_irq: periodic interrupt generator of a real-time clock,
 * with its own time counters and an AXI4-Lite register slave.
 * Assumes one 50 MHz clock, synchronous active-low reset, and an
 * oscillator-halt detect level synchronous to the clock.
 */
// Overview of operation
// RULE_01 - minute level: assert when seconds roll to zero
// RULE_02 - hour level: assert at zero minutes, seconds
// RULE_03 - month level: assert midnight on day one
// RULE_04 - pulse mode: 2/1 Hz square wave, second-aligned
// RULE_05 - level cycles: second, minute, hour, month
// RULE_06 - level falling edge coincides with second increment
// RULE_07 - trim perturbs timing once per twenty seconds
// RULE_08 - pulse low phase changes by at most 3.784ms
// RULE_09 - level one-second period deviates at most 3.784ms
// RULE_10 - pulse mode: seconds increment 92us after falling edge
// RULE_11 - host allows seconds lagging just after falling edge
// RULE_12 - seconds write clears divider, drives output low
// RULE_13 - codes 010/011 pulse 2/1 Hz, 100 per-second level
// RULE_14 - flag set while low; level write zero releases
`timescale 1ns/1ps
module rtcpig_periodic_irq #(
  parameter int CLK_HZ = rtcpig_pkg::CLK_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_halt_det,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_out_a_n,
  output logic irq
);
  import rtcpig_pkg::*;

  logic tick;
  rtcpig_tick_gen #(.CLK_HZ(CLK_HZ), .TICK_HZ(TICK_HZ)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // bus state
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [4:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // registers and core state
  logic [2:0] sel, next_sel;
  logic adj_en, next_adj_en;
  logic signed [7:0] adj, next_adj;
  logic [4:0] mlen, next_mlen;
  logic [1:0] imask, next_imask;
  logic [1:0] istat, next_istat;
  logic [5:0] sec, next_sec, min, next_min;
  logic [4:0] hour, next_hour, day, next_day;
  logic [14:0] sub, next_sub;
  logic [7:0] stall, next_stall;
  logic adj_used, next_adj_used;
  logic [4:0] adj_sec, next_adj_sec;
  logic skip_inc, next_skip_inc;
  logic periodic_irq_flag, next_flag;
  logic next_irq;
  rtcpig_mode_e mode;
  logic wr_go, rd_go, wr_hit, rd_hit, sec_wr, inc, evt;
  logic [7:0] adj_mag;
  logic [31:0] rd_val;

  always_comb begin
    unique case (sel)
      SEL_P2HZ[2:0]: mode = RTCPIG_PULSE2; // see RULE_13
      SEL_P1HZ[2:0]: mode = RTCPIG_PULSE1; // see RULE_13
      SEL_LSEC[2:0]: mode = RTCPIG_LSEC; // see RULE_13
      SEL_LMIN[2:0]: mode = RTCPIG_LMIN; // see RULE_05
      SEL_LHOUR[2:0]: mode = RTCPIG_LHOUR; // see RULE_05
      SEL_LMONTH[2:0]: mode = RTCPIG_LMONTH; // see RULE_05
      default: mode = RTCPIG_OFF;
    endcase
  end

  // bus: address and data taken in either order, answered together
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    wr_go = aw_held && w_held && !s_axi_bvalid;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end
    wr_hit = aw_addr[1:0] == 2'h0 && (aw_addr == OFF_CTRL ||
      aw_addr == OFF_FLAG || aw_addr == OFF_TIME || aw_addr == OFF_MLEN ||
      aw_addr == OFF_ISTAT || aw_addr == OFF_IMASK);
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    rd_go = s_axi_arvalid && s_axi_arready;
    rd_hit = s_axi_araddr[1:0] == 2'h0 && (s_axi_araddr == OFF_CTRL ||
      s_axi_araddr == OFF_FLAG || s_axi_araddr == OFF_TIME ||
      s_axi_araddr == OFF_MLEN || s_axi_araddr == OFF_ISTAT ||
      s_axi_araddr == OFF_IMASK);
    rd_val = 32'h0;
    unique case (s_axi_araddr)
      OFF_CTRL: begin
        rd_val[CTRL_SEL_LSB +: 3] = sel;
        rd_val[CTRL_ADJEN_BIT] = adj_en;
        rd_val[CTRL_ADJ_LSB +: 8] = adj;
      end
      OFF_FLAG: rd_val[0] = periodic_irq_flag;
      OFF_TIME: begin
        rd_val[TIME_SEC_LSB +: 6] = sec;
        rd_val[TIME_MIN_LSB +: 6] = min;
        rd_val[TIME_HOUR_LSB +: 5] = hour;
        rd_val[TIME_DAY_LSB +: 5] = day;
      end
      OFF_MLEN: rd_val[4:0] = mlen;
      OFF_ISTAT: rd_val[1:0] = istat;
      OFF_IMASK: rd_val[1:0] = imask;
      default: rd_val = 32'h0;
    endcase
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rdata = rd_val;
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      s_axi_arready <= !next_rvalid && !rd_go;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // timekeeping, trim and the interrupt pin
  always_comb begin
    next_sel = sel;
    next_adj_en = adj_en;
    next_adj = adj;
    next_mlen = mlen;
    next_imask = imask;
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_day = day;
    next_sub = sub;
    next_stall = stall;
    next_adj_used = adj_used;
    next_adj_sec = adj_sec;
    next_skip_inc = skip_inc;
    next_flag = periodic_irq_flag;
    next_istat = istat;
    inc = 1'b0;
    evt = 1'b0;
    sec_wr = 1'b0;
    adj_mag = adj[7] ? 8'(-adj) : 8'(adj);
    if (adj_mag > 8'(ADJ_MAX_TICKS)) begin
      adj_mag = 8'(ADJ_MAX_TICKS); // see RULE_08, RULE_09
    end
    if (tick) begin
      if (stall != 8'h0) begin
        next_stall = stall - 8'h1;
      end else if (sub == SUB_HALF_LAST && adj_en && !adj_used &&
                   adj_sec == 5'h0 && adj != 8'sh0) begin
        // one trim per twenty-second window, at the half second
        next_adj_used = 1'b1; // see RULE_07
        if (adj[7]) begin
          next_sub = SUB_HALF + 15'(adj_mag); // see RULE_08, RULE_09
        end else begin
          next_sub = SUB_HALF;
          next_stall = adj_mag - 8'h1; // see RULE_08, RULE_09
        end
      end else begin
        next_sub = sub + 15'h1;
        if (sub == 15'(INC_DELAY_TICKS)) begin
          inc = !skip_inc; // see RULE_10
          next_skip_inc = 1'b0;
        end
        if (next_sub == 15'h0) begin
          next_adj_used = 1'b0;
        end
      end
    end
    if (inc) begin
      next_adj_sec = (adj_sec == 5'(ADJ_PERIOD_S - 1)) ? 5'h0 :
        adj_sec + 5'h1;
      next_sec = sec + 6'h1;
      if (sec == 6'd59) begin
        next_sec = 6'h0;
        next_min = min + 6'h1;
        if (min == 6'd59) begin
          next_min = 6'h0;
          next_hour = hour + 5'h1;
          if (hour == 5'd23) begin
            next_hour = 5'h0;
            next_day = (day >= mlen) ? DAY_RST : day + 5'h1;
          end
        end
      end
      unique case (mode)
        RTCPIG_LSEC: evt = 1'b1; // see RULE_05, RULE_13
        RTCPIG_LMIN: evt = next_sec == 6'h0; // see RULE_01
        RTCPIG_LHOUR: evt = next_sec == 6'h0 && next_min == 6'h0; // see RULE_02
        RTCPIG_LMONTH: evt = next_sec == 6'h0 && next_min == 6'h0 &&
          next_hour == 5'h0 && next_day == DAY_RST; // see RULE_03
        default: evt = 1'b0;
      endcase
    end
    if (wr_go && wr_hit) begin
      unique case (aw_addr)
        OFF_CTRL: begin
          if (w_strb[0]) begin
            next_sel = w_data[CTRL_SEL_LSB +: 3];
            next_adj_en = w_data[CTRL_ADJEN_BIT];
          end
          if (w_strb[1]) begin
            next_adj = w_data[CTRL_ADJ_LSB +: 8];
          end
        end
        OFF_TIME: begin
          if (w_strb[0]) begin
            next_sec = w_data[TIME_SEC_LSB +: 6];
            sec_wr = 1'b1;
          end
          if (w_strb[1]) next_min = w_data[TIME_MIN_LSB +: 6];
          if (w_strb[2]) next_hour = w_data[TIME_HOUR_LSB +: 5];
          if (w_strb[3]) next_day = w_data[TIME_DAY_LSB +: 5];
        end
        OFF_MLEN: if (w_strb[0]) next_mlen = w_data[4:0];
        OFF_IMASK: if (w_strb[0]) next_imask = w_data[1:0];
        OFF_FLAG: begin
          // zero releases the pin in level mode; one does nothing
          if (w_strb[0] && !w_data[0]) next_flag = 1'b0; // see RULE_14
        end
        default: next_sel = next_sel;
      endcase
    end
    if (sec_wr) begin
      // restart the second; the increment is owed a full second later
      next_sub = 15'h0; // see RULE_12
      next_stall = 8'h0;
      next_adj_used = 1'b0;
      next_skip_inc = 1'b1;
    end
    unique case (mode)
      RTCPIG_PULSE1: next_flag = !next_sub[14]; // see RULE_04, RULE_13
      RTCPIG_PULSE2: next_flag = !next_sub[13]; // see RULE_04, RULE_13
      RTCPIG_OFF: next_flag = 1'b0;
      default: begin
        if (evt || sec_wr) next_flag = 1'b1; // see RULE_06, RULE_12
      end
    endcase
    if (evt || (next_flag && !periodic_irq_flag)) begin
      next_istat[ISTAT_PERIODIC_BIT] = 1'b1;
    end
    if (inc) next_istat[ISTAT_SECOND_BIT] = 1'b1;
    if (rd_go && s_axi_araddr == OFF_ISTAT) begin
      // a clear loses against an event in the same cycle
      next_istat = (evt || (next_flag && !periodic_irq_flag) ? 2'h1 : 2'h0) |
        (inc ? 2'h2 : 2'h0);
    end
    if (osc_halt_det) begin
      // a halted crystal invalidates control state and stops the pin
      next_sel = CTRL_SEL_RST;
      next_adj_en = 1'b0;
      next_adj = 8'sh0;
      next_flag = 1'b0;
    end
    next_irq = |(next_istat & next_imask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel <= CTRL_SEL_RST;
      adj_en <= 1'b0;
      adj <= 8'sh0;
      mlen <= MLEN_RST;
      imask <= 2'h0;
      istat <= 2'h0;
      sec <= 6'h0;
      min <= 6'h0;
      hour <= 5'h0;
      day <= DAY_RST;
      sub <= 15'h0;
      stall <= 8'h0;
      adj_used <= 1'b0;
      adj_sec <= 5'h0;
      skip_inc <= 1'b0;
      periodic_irq_flag <= 1'b0;
      irq_out_a_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      sel <= next_sel;
      adj_en <= next_adj_en;
      adj <= next_adj;
      mlen <= next_mlen;
      imask <= next_imask;
      istat <= next_istat;
      sec <= next_sec;
      min <= next_min;
      hour <= next_hour;
      day <= next_day;
      sub <= next_sub;
      stall <= next_stall;
      adj_used <= next_adj_used;
      adj_sec <= next_adj_sec;
      skip_inc <= next_skip_inc;
      periodic_irq_flag <= next_flag;
      irq_out_a_n <= !next_flag; // see RULE_14
      irq <= next_irq;
    end
  end
endmodule // rtcpig_periodic_irq

/* File: sim/rtcpig_checker.sv */
/* rtcpig_checker: pin and bus assertions for rtcpig_periodic_irq.
   assumes the master offers AW and W in the same cycle. */
`timescale 1ns/1ps
module rtcpig_checker #(
  parameter int CLK_HZ = rtcpig_pkg::CLK_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_halt_det,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_out_a_n,
  input wire logic irq
);
  import rtcpig_pkg::*;
  localparam int R = CLK_HZ / TICK_HZ;
  // trim acts at the half second and leaves the 1 Hz low phase alone; bounds allow its size anyway, plus tick granularity
  localparam int LO = (16384 - ADJ_MAX_TICKS) * R - 3;
  localparam int HI = (16384 + ADJ_MAX_TICKS) * R + 3;
  logic wr, ctl, sec, clr, full;
  logic [2:0] csel, hist;
  int lowcnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign ctl = wr & s_axi_wstrb[0] & (s_axi_awaddr == OFF_CTRL);
  assign sec = wr & s_axi_wstrb[0] & (s_axi_awaddr == OFF_TIME);
  assign clr = wr & s_axi_wstrb[0] & (s_axi_awaddr == OFF_FLAG) &
    ~s_axi_wdata[0];
  // full: the low phase started from a cleared divider, not mid-second
  always_ff @(posedge aclk) begin
    if (!aresetn || osc_halt_det) begin
      csel <= 3'h0;
      full <= 1'b0;
    end else begin
      if (ctl)
        csel <= s_axi_wdata[2:0];
      full <= sec | (full & ~ctl);
    end
    hist <= {hist[1:0], ctl | clr};
    lowcnt <= (irq_out_a_n | sec) ? 0 : lowcnt + 1;
  end
  // both halves are held for one cycle before the answer registers
  a_write_answer: assert property (wr |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_reset_quiet: assert property ($rose(aresetn) |-> irq_out_a_n && !irq)
    else $error("outputs active after reset");
  a_halt_pin_off: assert property (osc_halt_det |=> irq_out_a_n)
    else $error("pin low during oscillator halt");
  a_secwr_low: assert property (
    sec && csel > 3'h1 && !osc_halt_det |-> ##[1:3] !irq_out_a_n)
    else $error("seconds write left pin high");
  a_level_hold: assert property (
    csel[2] && !irq_out_a_n && hist == 3'h0 && !ctl && !clr &&
    !osc_halt_det |=> !irq_out_a_n) else $error("level pin released");
  a_flag_release: assert property (
    clr && csel[2] && !osc_halt_det |-> ##[1:3] irq_out_a_n)
    else $error("flag clear did not release pin");
  a_pulse_low: assert property (
    full && csel == SEL_P1HZ[2:0] && $rose(irq_out_a_n)
    |-> lowcnt >= LO && lowcnt <= HI) else $error("pulse low length");
endmodule // rtcpig_checker

/* File: sim/rtcpig_host_model.sv */
/* rtcpig_host_model: host end of the interrupt pin, times low phases.
   assumes the pin is sampled on the system clock. */
`timescale 1ns/1ps
module rtcpig_host_model (
  input wire logic aclk,
  input wire logic irq_n,
  output int low_len
);
  int cnt;
  initial begin
    cnt = 0;
    low_len = 0;
  end
  // a host reading time right after a fall expects it may lag a second
  always @(posedge aclk) begin
    if (irq_n === 1'b0)
      cnt <= cnt + 1;
    else if (cnt != 0) begin
      low_len <= cnt;
      cnt <= 0;
    end
  end
endmodule // rtcpig_host_model

/* File: sim/testbench.sv */
/* testbench: drives rtcpig_periodic_irq over AXI4-Lite against a time
   model. assumes CLK_HZ equal to the timebase, one tick per clock. */
`timescale 1ns/1ps
module testbench;
  import rtcpig_pkg::*;
  localparam int HZ = 32768;
  logic aclk, aresetn, osc_halt_det, irq_out_a_n, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, t;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares, comparisons, low_len, m, n, i;
  rtcpig_periodic_irq #(.CLK_HZ(HZ)) i_dut (.*);
  rtcpig_host_model i_host (.aclk(aclk), .irq_n(irq_out_a_n),
    .low_len(low_len));
  function automatic logic [31:0] adv(input logic [31:0] v, input int ml);
    int s, mi, h, d;
    s = v[5:0] + 1;
    mi = v[13:8];
    h = v[20:16];
    d = v[28:24];
    if (s == 60) begin
      s = 0;
      mi++;
    end
    if (mi == 60) begin
      mi = 0;
      h++;
    end
    if (h == 24) begin
      h = 0;
      d++;
    end
    if (d > ml)
      d = 1;
    return {3'h0, d[4:0], 3'h0, h[4:0], 2'h0, mi[5:0], 2'h0, s[5:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
      end
    end while (s_axi_bready && k < 40);
    // let one edge pass so the next call never re-drives bready at once
    @(posedge aclk);
    if (k >= 40) begin
      chk(0, 1);
      results();
    end
  endtask
  task automatic rdr(input logic [4:0] a, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        chk(s_axi_rresp, er);
      end
    end while (s_axi_rready && k < 40);
    @(posedge aclk);
    if (k >= 40) begin
      chk(0, 1);
      results();
    end
  endtask
  // bounded wait for the pin level; n holds the cycles spent
  task automatic wait_pin(input logic lvl, input int lim);
    n = 0;
    while (irq_out_a_n !== lvl) begin
      @(posedge aclk);
      n++;
      if (n > lim) begin
        chk(0, 1);
        results();
      end
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    {aresetn, osc_halt_det, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(32'hc352));
    m = $urandom_range(31, 28);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (i = 0; i < 6; i++) begin
      rdr(5'(i * 4), RESP_OKAY);
      // first increment comes on the fifth tick after reset, before the time read
      chk(rd, i == 2 ? 32'h01000001 : i == 3 ? 32'h1f :
        i == 4 ? 32'h2 : 32'h0);
    end
    rdr(5'h18, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(5'h18, 32'h5, RESP_SLVERR);
    wr(OFF_MLEN, 32'(m), RESP_OKAY);
    rdr(OFF_MLEN, RESP_OKAY);
    chk(rd, 32'(m));
    // 1 Hz from a cleared divider, then 2 Hz in the second half
    t = {3'h0, m[4:0], 8'h17, 8'h3b, 8'h3b};
    wr(OFF_CTRL, 32'(SEL_P1HZ), RESP_OKAY);
    wr(OFF_TIME, t, RESP_OKAY);
    chk(irq_out_a_n, 1'b0);
    wait_pin(1'b1, 20000);
    chk(n > HZ / 2 - 12 && n <= HZ / 2, 1'b1);
    wr(OFF_CTRL, 32'(SEL_P2HZ), RESP_OKAY);
    wait_pin(1'b1, 9000);
    @(posedge aclk);
    chk(low_len > HZ / 4 - 12 && low_len <= HZ / 4, 1'b1);
    wait_pin(1'b0, 9000);
    rdr(OFF_TIME, RESP_OKAY);
    chk(rd, t);
    repeat (8) @(posedge aclk);
    rdr(OFF_TIME, RESP_OKAY);
    chk(rd, adv(t, m));
    // minute level with the interrupt unmasked
    wr(OFF_IMASK, 32'h1, RESP_OKAY);
    wr(OFF_CTRL, 32'(SEL_LMIN), RESP_OKAY);
    t = 32'h0100003b;
    wr(OFF_TIME, t, RESP_OKAY);
    chk(irq_out_a_n, 1'b0);
    rdr(OFF_FLAG, RESP_OKAY);
    chk(rd, 32'h1);
    wr(OFF_FLAG, 32'h1, RESP_OKAY);
    chk(irq_out_a_n, 1'b0);
    wr(OFF_FLAG, 32'h0, RESP_OKAY);
    chk(irq_out_a_n, 1'b1);
    rdr(OFF_ISTAT, RESP_OKAY);
    wait_pin(1'b0, 34000);
    chk(n > HZ - 60 && n < HZ + 8, 1'b1);
    rdr(OFF_TIME, RESP_OKAY);
    chk(rd, adv(t, m));
    chk(irq, 1'b1);
    rdr(OFF_ISTAT, RESP_OKAY);
    chk(rd, 32'h3);
    chk(irq, 1'b0);
    // hour code: a seconds write raises the flag at once
    wr(OFF_CTRL, 32'(SEL_LHOUR), RESP_OKAY);
    wr(OFF_FLAG, 32'h0, RESP_OKAY);
    chk(irq_out_a_n, 1'b1);
    wr(OFF_TIME, 32'h01003b3b, RESP_OKAY);
    chk(irq_out_a_n, 1'b0);
    // month level, masked: the pin falls but irq stays low
    wr(OFF_IMASK, 32'h0, RESP_OKAY);
    wr(OFF_CTRL, 32'(SEL_LMONTH), RESP_OKAY);
    t = {3'h0, m[4:0], 8'h17, 8'h3b, 8'h3b};
    wr(OFF_TIME, t, RESP_OKAY);
    wr(OFF_FLAG, 32'h0, RESP_OKAY);
    chk(irq_out_a_n, 1'b1);
    wait_pin(1'b0, 34000);
    rdr(OFF_TIME, RESP_OKAY);
    chk(rd, adv(t, m));
    chk(irq, 1'b0);
    osc_halt_det <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(irq_out_a_n, 1'b1);
    osc_halt_det <= 1'b0;
    rdr(OFF_CTRL, RESP_OKAY);
    chk(rd, 32'h0);
    results();
  end
endmodule // testbench
bind rtcpig_periodic_irq rtcpig_checker #(.CLK_HZ(CLK_HZ)) i_chk (.*);
